// ===== hw/pms_consts.svh
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// register byte offsets on the bus
`define PMS_ADDR_W 6
`define PMS_OFF_CMD 6'h00
`define PMS_OFF_SEL 6'h04
`define PMS_OFF_RDATA 6'h08
`define PMS_OFF_MSTAT 6'h0c
`define PMS_OFF_PST1 6'h10
`define PMS_OFF_IDHI 6'h14
`define PMS_OFF_IDLO 6'h18
`define PMS_OFF_REVID 6'h1c
`define PMS_OFF_PST2 6'h20
`define PMS_OFF_ISTAT 6'h24
`define PMS_OFF_IMASK 6'h28

// phy register addresses seen by the management engine
`define PMS_PHY_PST1 5'h01
`define PMS_PHY_IDHI 5'h02
`define PMS_PHY_IDLO 5'h03
`define PMS_PHY_PST2 5'h11

// field positions
`define PMS_CMD_READ 0
`define PMS_CMD_SCAN 1
`define PMS_ST_BUSY 0
`define PMS_ST_SCAN 1
`define PMS_ST_INVALID 2
`define PMS_P1_FDPX 12
`define PMS_P1_HDPX 11
`define PMS_P1_LL 2
`define PMS_P1_JB 1
`define PMS_P2_TX 13
`define PMS_P2_RX 12
`define PMS_P2_LINK 10
`define PMS_IRQ_DONE 0
`define PMS_IRQ_LINK 1
`define PMS_IRQ_JAB 2

// timing
`define PMS_CLK_NS 50
`define PMS_MGMT_READ_NS 800
`define PMS_READ_CYC ((`PMS_MGMT_READ_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)

`endif

// ===== hw/pms_pkg.sv
package pms_pkg;
   `include "pms_consts.svh"

   typedef enum logic {PMS_IDLE, PMS_READ} pms_mst_e;

   typedef struct packed {
      logic [1:0] lnk_sy;
      logic [1:0] jab_sy;
      logic [1:0] tx_sy;
      logic [1:0] rx_sy;
      logic cmd_scan;
      logic cmd_read;
      logic [4:0] regsel;
      logic [15:0] rdata;
      logic rd_invalid;
      pms_mst_e mst;
      logic [4:0] cnt;
      logic [4:0] op_addr;
      logic ll;
      logic jb;
      logic [2:0] ists;
      logic [2:0] imask;
      logic irq;
      logic wreq;
      logic [31:0] bus_rd;
   } pms_state_s;
endpackage : pms_pkg

// ===== hw/pms_regs.sv
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module pms_regs import pms_pkg::*; #(
   // arbitrary identity values
   parameter logic [21:0] MAKER_BITS = 22'h2a_5a5c,
   parameter logic [5:0] PART_NUM = 6'h15,
   parameter logic [3:0] PHY_REV = 4'h3,
   parameter logic [4:0] SILICON_REV = 5'h02
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // phy condition pins
   input wire logic link_up,
   input wire logic jabber_detect,
   input wire logic phy_tx_active,
   input wire logic phy_rx_active,
   // interrupt
   output logic irq
);

   localparam int RD_LAT = `PMS_READ_CYC;
   localparam logic [15:0] ID_HI = MAKER_BITS[21:6];
   localparam logic [15:0] ID_LO = {MAKER_BITS[5:0], PART_NUM, PHY_REV};

   pms_state_s s_q;
   pms_state_s s_d;

   logic lnk;
   logic jab;
   logic acc;
   logic wr0;
   logic rd_p1;
   logic rd_ist;
   logic fin;
   logic clr1;
   logic [2:0] ev;

   ////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
      return a[5:2] == off[5:2];
   endfunction : hit

   function automatic logic [15:0] pst1(input pms_state_s s);
      logic [15:0] w;
      w = 16'h0000;
      w[`PMS_P1_FDPX] = 1'b1;
      w[`PMS_P1_HDPX] = 1'b1;
      w[`PMS_P1_LL] = s.ll;
      w[`PMS_P1_JB] = s.jb;
      return w;
   endfunction : pst1

   function automatic logic [15:0] pst2(input pms_state_s s);
      logic [15:0] w;
      w = 16'h0000;
      w[`PMS_P2_TX] = s.tx_sy[1];
      w[`PMS_P2_RX] = s.rx_sy[1];
      w[`PMS_P2_LINK] = s.lnk_sy[1];
      return w;
   endfunction : pst2

   function automatic logic [15:0] phy_val(input logic [4:0] ra, input pms_state_s s);
      logic [15:0] w;
      w = 16'h0000;
      case (ra)
         `PMS_PHY_PST1: w = pst1(s);
         `PMS_PHY_IDHI: w = ID_HI;
         `PMS_PHY_IDLO: w = ID_LO;
         `PMS_PHY_PST2: w = pst2(s);
         default: w = 16'h0000;
      endcase
      return w;
   endfunction : phy_val

   function automatic logic [31:0] rmux(input logic [5:0] a, input pms_state_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (hit(a, `PMS_OFF_CMD)) begin
         w[`PMS_CMD_SCAN] = s.cmd_scan;
         w[`PMS_CMD_READ] = s.cmd_read;
      end else if (hit(a, `PMS_OFF_SEL)) begin
         w[4:0] = s.regsel;
      end else if (hit(a, `PMS_OFF_RDATA)) begin
         w[15:0] = s.rdata;
      end else if (hit(a, `PMS_OFF_MSTAT)) begin
         w[`PMS_ST_INVALID] = s.rd_invalid;
         w[`PMS_ST_SCAN] = s.cmd_scan;
         w[`PMS_ST_BUSY] = (s.mst == PMS_READ);
      end else if (hit(a, `PMS_OFF_PST1)) begin
         w[15:0] = pst1(s);
      end else if (hit(a, `PMS_OFF_IDHI)) begin
         w[15:0] = ID_HI;
      end else if (hit(a, `PMS_OFF_IDLO)) begin
         w[15:0] = ID_LO;
      end else if (hit(a, `PMS_OFF_REVID)) begin
         w[4:0] = SILICON_REV;
      end else if (hit(a, `PMS_OFF_PST2)) begin
         w[15:0] = pst2(s);
      end else if (hit(a, `PMS_OFF_ISTAT)) begin
         w[2:0] = s.ists;
      end else if (hit(a, `PMS_OFF_IMASK)) begin
         w[2:0] = s.imask;
      end
      return w;
   endfunction : rmux

   ////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;

      // pin synchronisers
      s_d.lnk_sy = {s_q.lnk_sy[0], link_up};
      s_d.jab_sy = {s_q.jab_sy[0], jabber_detect};
      s_d.tx_sy = {s_q.tx_sy[0], phy_tx_active};
      s_d.rx_sy = {s_q.rx_sy[0], phy_rx_active};
      lnk = s_q.lnk_sy[1];
      jab = s_q.jab_sy[1];

      // bus handshake: one wait cycle, then answer
      acc = (avs_read || avs_write) && s_q.wreq;
      s_d.wreq = !acc;
      wr0 = acc && avs_write && avs_byteenable[0];
      rd_p1 = acc && avs_read && hit(avs_address, `PMS_OFF_PST1);
      rd_ist = acc && avs_read && hit(avs_address, `PMS_OFF_ISTAT);
      if (acc && avs_read) begin
         s_d.bus_rd = rmux(avs_address, s_q);
      end

      // management engine
      fin = (s_q.mst == PMS_READ) && (s_q.cnt == 5'h00);
      case (s_q.mst)
         PMS_IDLE: begin
            if (s_q.cmd_scan || s_q.cmd_read) begin
               s_d.mst = PMS_READ;
               s_d.cnt = 5'(RD_LAT - 1);
               s_d.op_addr = s_q.regsel;
               s_d.rd_invalid = 1'b1;
            end
         end
         PMS_READ: begin
            if (fin) begin
               s_d.mst = PMS_IDLE;
               s_d.rdata = phy_val(s_q.op_addr, s_q);
               s_d.rd_invalid = 1'b0;
               s_d.cmd_read = 1'b0;
            end else begin
               s_d.cnt = s_q.cnt - 5'h01;
            end
         end
         default: s_d.mst = PMS_IDLE;
      endcase

      // latching status bits, reread loads the live level
      clr1 = rd_p1 || (fin && s_q.op_addr == `PMS_PHY_PST1);
      s_d.ll = clr1 ? lnk : (s_q.ll & lnk);
      s_d.jb = clr1 ? jab : (s_q.jb | jab);

      // register writes; reserved and read-only words ignore writes
      if (wr0 && hit(avs_address, `PMS_OFF_CMD)) begin
         s_d.cmd_scan = avs_writedata[`PMS_CMD_SCAN];
         s_d.cmd_read = avs_writedata[`PMS_CMD_READ];
      end
      if (wr0 && hit(avs_address, `PMS_OFF_SEL)) begin
         s_d.regsel = avs_writedata[4:0];
      end
      if (wr0 && hit(avs_address, `PMS_OFF_IMASK)) begin
         s_d.imask = avs_writedata[2:0];
      end

      // sticky events, read clears, new event wins
      ev = 3'h0;
      ev[`PMS_IRQ_DONE] = fin;
      ev[`PMS_IRQ_LINK] = s_q.ll && !lnk;
      ev[`PMS_IRQ_JAB] = !s_q.jb && jab;
      s_d.ists = (rd_ist ? 3'h0 : s_q.ists) | ev;
      s_d.irq = |(s_d.ists & s_d.imask);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
         s_q.wreq <= 1'b1;
         s_q.mst <= PMS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.bus_rd;
   assign avs_waitrequest = s_q.wreq;
   assign irq = s_q.irq;

   ////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   property p_scan_restart;
      (s_q.cmd_scan && s_q.mst == PMS_IDLE) |=> (s_q.mst == PMS_READ);
   endproperty
   a_scan_restart: assert property (p_scan_restart)
      else $error("scan did not start a new read");

   property p_single_once;
      (fin && !s_q.cmd_scan && !(wr0 && hit(avs_address, `PMS_OFF_CMD)))
         |=> !s_q.cmd_read ##1 (s_q.mst == PMS_IDLE);
   endproperty
   a_single_once: assert property (p_single_once)
      else $error("single read repeated");

   property p_cmd_zero;
      (acc && avs_read && hit(avs_address, `PMS_OFF_CMD))
         |=> (avs_readdata[31:2] == 30'h0);
   endproperty
   a_cmd_zero: assert property (p_cmd_zero)
      else $error("command register upper bits not zero");

   property p_result;
      (fin && s_q.op_addr == `PMS_PHY_IDHI) |=> (!s_q.rd_invalid && s_q.rdata == ID_HI);
   endproperty
   a_result: assert property (p_result)
      else $error("read data or invalid flag wrong after read");

   property p_invalid_hold;
      $rose(s_q.mst == PMS_READ) |-> s_q.rd_invalid [*3];
   endproperty
   a_invalid_hold: assert property (p_invalid_hold)
      else $error("invalid flag dropped early");

   property p_scan_flag;
      (acc && avs_read && hit(avs_address, `PMS_OFF_MSTAT))
         |=> (avs_readdata[`PMS_ST_SCAN] == $past(s_q.cmd_scan)
              && avs_readdata[31:3] == 29'h0);
   endproperty
   a_scan_flag: assert property (p_scan_flag)
      else $error("scan flag misreported");

   property p_busy_len;
      $rose(s_q.mst == PMS_READ) |-> ##RD_LAT (s_q.mst == PMS_IDLE);
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length wrong");

   property p_link_low;
      (!lnk && !clr1) |=> !s_q.ll;
   endproperty
   a_link_low: assert property (p_link_low)
      else $error("latched link not low after link loss");

   property p_jab_high;
      jab |=> s_q.jb;
   endproperty
   a_jab_high: assert property (p_jab_high)
      else $error("jabber bit not latched");

   property p_caps;
      (acc && avs_read && hit(avs_address, `PMS_OFF_PST1))
         |=> (avs_readdata[12:11] == 2'b11 && avs_readdata[10:3] == 8'h00
              && avs_readdata[31:13] == 19'h0 && !avs_readdata[0]);
   endproperty
   a_caps: assert property (p_caps)
      else $error("phy status capability bits wrong");

   property p_idlo;
      (acc && avs_read && hit(avs_address, `PMS_OFF_IDLO))
         |=> (avs_readdata[15:10] == MAKER_BITS[5:0]);
   endproperty
   a_idlo: assert property (p_idlo)
      else $error("identity low maker bits wrong");

   property p_rev;
      (acc && avs_read && hit(avs_address, `PMS_OFF_REVID))
         |=> (avs_readdata == {27'h0, SILICON_REV});
   endproperty
   a_rev: assert property (p_rev)
      else $error("silicon revision wrong");

   property p_irq;
      (s_q.ists[`PMS_IRQ_DONE] && s_q.imask[`PMS_IRQ_DONE] && !rd_ist) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised");

   property p_wait;
      acc |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait)
      else $error("waitrequest sequence wrong");

   property p_busy_on;
      (acc && avs_read && hit(avs_address, `PMS_OFF_MSTAT) && s_q.mst == PMS_READ)
         |=> avs_readdata[`PMS_ST_BUSY];
   endproperty
   a_busy_on: assert property (p_busy_on)
      else $error("busy flag low during read");

   property p_busy_off;
      (acc && avs_read && hit(avs_address, `PMS_OFF_MSTAT) && s_q.mst == PMS_IDLE)
         |=> !avs_readdata[`PMS_ST_BUSY];
   endproperty
   a_busy_off: assert property (p_busy_off)
      else $error("busy flag high while idle");

   property p_invalid_flag;
      (acc && avs_read && hit(avs_address, `PMS_OFF_MSTAT))
         |=> (avs_readdata[`PMS_ST_INVALID] == $past(s_q.rd_invalid));
   endproperty
   a_invalid_flag: assert property (p_invalid_flag)
      else $error("invalid flag misreported");

   property p_scan_select;
      (s_q.mst == PMS_IDLE && s_q.cmd_scan) |=> (s_q.op_addr == $past(s_q.regsel));
   endproperty
   a_scan_select: assert property (p_scan_select)
      else $error("scan read used wrong phy register");

   property p_link_reload;
      (clr1 && lnk) |=> s_q.ll;
   endproperty
   a_link_reload: assert property (p_link_reload)
      else $error("latched link not reloaded by status read");

   property p_jab_clear;
      (rd_p1 && !jab) |=> !s_q.jb;
   endproperty
   a_jab_clear: assert property (p_jab_clear)
      else $error("jabber bit not cleared by status read");

   property p_idhi;
      (acc && avs_read && hit(avs_address, `PMS_OFF_IDHI))
         |=> (avs_readdata == {16'h0000, MAKER_BITS[21:6]});
   endproperty
   a_idhi: assert property (p_idhi)
      else $error("identity high maker bits wrong");

   property p_live;
      (acc && avs_read && hit(avs_address, `PMS_OFF_PST2))
         |=> (avs_readdata[`PMS_P2_TX] == $past(s_q.tx_sy[1])
              && avs_readdata[`PMS_P2_LINK] == $past(lnk));
   endproperty
   a_live: assert property (p_live)
      else $error("live phy status misreported");

   property p_irq_level;
      irq == |(s_q.ists & s_q.imask);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level does not follow status and mask");

   property p_done_sticky;
      (s_q.ists[`PMS_IRQ_DONE] && !rd_ist) |=> s_q.ists[`PMS_IRQ_DONE];
   endproperty
   a_done_sticky: assert property (p_done_sticky)
      else $error("read done status lost without read");

endmodule : pms_regs

// ===== verification/test_phy_mgmt_status_regs.sv
`timescale 1ns/1ps
`include "pms_consts.svh"
module test_phy_mgmt_status_regs;
   import pms_pkg::*;
   // identity values are arbitrary
   localparam logic [21:0] MAKER = 22'h15_c3a7;
   localparam logic [5:0] PART = 6'h2b;
   localparam logic [3:0] PREV = 4'h9;
   localparam logic [4:0] SREV = 5'h11;
   localparam logic [31:0] ID_HI = {16'h0000, MAKER[21:6]};
   localparam logic [31:0] ID_LO = {16'h0000, MAKER[5:0], PART, PREV};

   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic link_up = 1'b1;
   logic jabber_detect = 1'b0;
   logic phy_tx_active = 1'b0;
   logic phy_rx_active = 1'b0;
   logic irq;
   int bad_count = 0;
   int num_checks = 0;
   logic [31:0] rd;

   always #25 ref_clk = ~ref_clk;

   pms_regs #(.MAKER_BITS(MAKER), .PART_NUM(PART), .PHY_REV(PREV), .SILICON_REV(SREV)) DUT (
      .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_up(link_up),
      .jabber_detect(jabber_detect), .phy_tx_active(phy_tx_active),
      .phy_rx_active(phy_rx_active), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 50) begin
         bad_count++;
         conclude();
      end
   endtask : bus

   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdchk

   // poll management status until bit b equals v
   task automatic wait_bit(input int b, input logic v);
      int n;
      for (n = 0; n < 200; n++) begin
         bus(1'b0, `PMS_OFF_MSTAT, 32'h0000_0000);
         if (rd[b] === v) break;
      end
      if (n == 200) begin
         bad_count++;
         conclude();
      end
   endtask : wait_bit

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_constants();
      rdchk(`PMS_OFF_CMD, 32'h0000_0000);
      bus(1'b1, `PMS_OFF_MSTAT, 32'h0000_0003);
      rdchk(`PMS_OFF_MSTAT, 32'h0000_0000);
      bus(1'b1, `PMS_OFF_IDHI, 32'h0000_0000);
      rdchk(`PMS_OFF_IDHI, ID_HI);
      bus(1'b1, `PMS_OFF_IDLO, 32'h0000_ffff);
      rdchk(`PMS_OFF_IDLO, ID_LO);
      rdchk(`PMS_OFF_REVID, {27'h0, SREV});
      bus(1'b1, `PMS_OFF_CMD, 32'h0000_00fc);
      rdchk(`PMS_OFF_CMD, 32'h0000_0000);
      rdchk(6'h2c, 32'h0000_0000);
   endtask : t_constants

   task automatic t_single_read();
      bus(1'b1, `PMS_OFF_SEL, {27'h0, `PMS_PHY_IDHI});
      bus(1'b1, `PMS_OFF_CMD, 32'h0000_0001);
      rdchk(`PMS_OFF_MSTAT, 32'h0000_0005);
      wait_bit(`PMS_ST_BUSY, 1'b0);
      rdchk(`PMS_OFF_RDATA, ID_HI);
      rdchk(`PMS_OFF_MSTAT, 32'h0000_0000);
      rdchk(`PMS_OFF_CMD, 32'h0000_0000);
      bus(1'b1, `PMS_OFF_IMASK, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      rdchk(`PMS_OFF_ISTAT, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
   endtask : t_single_read

   task automatic t_scan();
      bus(1'b1, `PMS_OFF_SEL, {27'h0, `PMS_PHY_IDLO});
      bus(1'b1, `PMS_OFF_CMD, 32'h0000_0002);
      rdchk(`PMS_OFF_MSTAT, 32'h0000_0007);
      wait_bit(`PMS_ST_INVALID, 1'b0);
      rdchk(`PMS_OFF_RDATA, ID_LO);
      wait_bit(`PMS_ST_BUSY, 1'b0);
      wait_bit(`PMS_ST_BUSY, 1'b1);
      bus(1'b1, `PMS_OFF_CMD, 32'h0000_0000);
      wait_bit(`PMS_ST_BUSY, 1'b0);
      rdchk(`PMS_OFF_MSTAT, 32'h0000_0000);
   endtask : t_scan

   task automatic t_latches();
      bus(1'b1, `PMS_OFF_IMASK, 32'h0000_0007);
      rdchk(`PMS_OFF_ISTAT, 32'h0000_0001);
      rdchk(`PMS_OFF_PST1, 32'h0000_1800);
      rdchk(`PMS_OFF_PST1, 32'h0000_1804);
      link_up <= 1'b0;
      repeat (4) @(posedge ref_clk);
      link_up <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0000_0001);
      rdchk(`PMS_OFF_PST1, 32'h0000_1800);
      rdchk(`PMS_OFF_PST1, 32'h0000_1804);
      rdchk(`PMS_OFF_ISTAT, 32'h0000_0002);
      chk({31'h0, irq}, 32'h0000_0000);
      jabber_detect <= 1'b1;
      repeat (3) @(posedge ref_clk);
      jabber_detect <= 1'b0;
      repeat (6) @(posedge ref_clk);
      bus(1'b1, `PMS_OFF_PST1, 32'h0000_0000);
      rdchk(`PMS_OFF_PST1, 32'h0000_1806);
      rdchk(`PMS_OFF_PST1, 32'h0000_1804);
      bus(1'b1, `PMS_OFF_IMASK, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      rdchk(`PMS_OFF_ISTAT, 32'h0000_0004);
   endtask : t_latches

   task automatic t_live();
      phy_tx_active <= 1'b1;
      phy_rx_active <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdchk(`PMS_OFF_PST2, 32'h0000_3400);
      phy_tx_active <= 1'b0;
      link_up <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rdchk(`PMS_OFF_PST2, 32'h0000_1000);
      rdchk(`PMS_OFF_PST1, 32'h0000_1800);
      bus(1'b1, `PMS_OFF_PST2, 32'h0000_ffff);
      rdchk(`PMS_OFF_PST2, 32'h0000_1000);
      rdchk(`PMS_OFF_PST1, 32'h0000_1800);
   endtask : t_live

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_constants();
      t_single_read();
      t_scan();
      t_latches();
      t_live();
      conclude();
   end
endmodule : test_phy_mgmt_status_regs
